// ==== src/jid_defs.svh ====
`ifndef JID_DEFS_SVH
`define JID_DEFS_SVH

// ==========================================================
// instruction register
`define JID_IR_W          16
`define JID_IR_RESET      16'h0004
`define JID_IR_CAPTURE    16'h0001
`define JID_IR_EXTEST     16'h0000
`define JID_IR_SAMPLE     16'h0002
`define JID_IR_IDCODE     16'h0004
`define JID_IR_BYPASS     16'hFFFF
`define JID_IR_FL_CTRL    16'h0082
`define JID_IR_FL_DATA    16'h0083
`define JID_IR_FL_ADDR    16'h0084
`define JID_IR_FL_SCALE   16'h0085

// ==========================================================
// data registers
`define JID_ID_W          32
// arbitrary identification value, lsb set as the scan standard demands
`define JID_IDCODE_VAL    32'h0000_1001
`define JID_IND_W         20
`define JID_IND_OP_HI     19
`define JID_IND_OP_LO     18
`define JID_IND_DATA_W    18
`define JID_IND_WR_BIT    18

// ==========================================================
// link pin synchroniser reset image: tck, tms, tdi low, trst_n high
`define JID_PIN_RESET     4'h8

`endif

// ==== src/jid_pkg.sv ====
`include "jid_defs.svh"

package jid_pkg;

  // ==========================================================
  // test access port controller states
  typedef enum logic [15:0] {
    TAP_RESET   = 16'h0001,
    TAP_IDLE    = 16'h0002,
    TAP_SEL_DR  = 16'h0004,
    TAP_CAP_DR  = 16'h0008,
    TAP_SH_DR   = 16'h0010,
    TAP_EX1_DR  = 16'h0020,
    TAP_PA_DR   = 16'h0040,
    TAP_EX2_DR  = 16'h0080,
    TAP_UPD_DR  = 16'h0100,
    TAP_SEL_IR  = 16'h0200,
    TAP_CAP_IR  = 16'h0400,
    TAP_SH_IR   = 16'h0800,
    TAP_EX1_IR  = 16'h1000,
    TAP_PA_IR   = 16'h2000,
    TAP_EX2_IR  = 16'h4000,
    TAP_UPD_IR  = 16'h8000
  } jid_tap_t;

  // ==========================================================
  // data register placed in the scan path
  typedef enum logic [3:0] {
    DR_ID  = 4'h1,
    DR_BYP = 4'h2,
    DR_BSR = 4'h4,
    DR_IND = 4'h8
  } jid_dr_t;

endpackage

// ==== src/jid_sync.sv ====
`timescale 1ns/10ps

// ==========================================================
// two-flop synchroniser for pins from the link
module jid_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule // jid_sync

// ==== src/jid_top.sv ====
`timescale 1ns/10ps
`include "jid_defs.svh"

// Summary of operation
// - IR holding 0x0004 puts the 32-bit identification register in the scan path.
// - IR holding 0xFFFF puts the bypass register between serial input and output.
// - IR 0x0082 routes scans to the flash interface control register.
// - IR 0x0083 routes scans to the flash interface data register.
// - IR 0x0084 routes scans to the flash address register.
// - IR 0x0085 routes scans to the flash timing prescale register.
// - IR is sixteen bits; test logic reset loads the identification instruction.
// - code 0 selects boundary register for full control; code 2 observes only.
// - bypass path is one bit; identification path is thirty-two bits.
// - indirect access: op field bits 19:18 above 18-bit data; poll, read, write.
module jid_top
  import jid_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  input  wire logic        trst_n,
  output logic             tdo,
  output logic             tdo_oe,
  input  wire logic        bsr_tdo,
  output logic             bsr_capture,
  output logic             bsr_shift,
  output logic             bsr_update,
  output logic             bsr_tdi,
  output logic             bsr_extest,
  output logic             bsr_sel,
  input  wire logic [17:0] ind_rdata,
  input  wire logic        ind_busy,
  output logic             ind_capture,
  output logic             ind_update,
  output logic [1:0]       ind_reg_sel,
  output logic [1:0]       ind_op,
  output logic [17:0]      ind_wdata
);

  // ==========================================================
  // link pins, sampled by the system clock
  logic [3:0] pins_s;
  logic       tck_d_ff;

  jid_sync #(.W(4), .RST_VAL(`JID_PIN_RESET)) u_pin_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       ({trst_n, tdi, tms, tck}),
    .q       (pins_s)
  );

  wire tck_s   = pins_s[0];
  wire tms_s   = pins_s[1];
  wire tdi_s   = pins_s[2];
  wire trstn_s = pins_s[3];
  // 80 ns link period gives ~5 system cycles per phase, ample for edge finding
  wire tck_rise = tck_s & ~tck_d_ff;
  wire tck_fall = ~tck_s & tck_d_ff;

  always_ff @(posedge sys_clk) begin
    if (!rstn) tck_d_ff <= 1'b0;
    else       tck_d_ff <= tck_s;
  end

  // ==========================================================
  // controller state
  jid_tap_t state_ff, nxt_state;

  always_comb begin
    case (state_ff)
      TAP_RESET:  nxt_state = tms_s ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   nxt_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt_state = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nxt_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  nxt_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: nxt_state = tms_s ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  nxt_state = tms_s ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: nxt_state = tms_s ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: nxt_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nxt_state = tms_s ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: nxt_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  nxt_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: nxt_state = tms_s ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  nxt_state = tms_s ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: nxt_state = tms_s ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: nxt_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
      default:    nxt_state = TAP_RESET;
    endcase
  end

  // test reset pin forces the controller home regardless of tck
  always_ff @(posedge sys_clk) begin
    if (!rstn || !trstn_s) state_ff <= TAP_RESET;
    else if (tck_rise)     state_ff <= nxt_state;
  end

  wire st_cap_dr = tck_rise && (state_ff == TAP_CAP_DR);
  wire st_sh_dr  = tck_rise && (state_ff == TAP_SH_DR);
  wire st_upd_dr = tck_rise && (state_ff == TAP_UPD_DR);

  // ==========================================================
  // instruction register: shift stage and active copy
  logic [`JID_IR_W-1:0] ir_sh_ff;
  logic [`JID_IR_W-1:0] ir_ff;

  always_ff @(posedge sys_clk) begin
    if (!rstn || state_ff == TAP_RESET) begin
      ir_sh_ff <= `JID_IR_CAPTURE;
      ir_ff    <= `JID_IR_RESET;
    end else if (tck_rise) begin
      if (state_ff == TAP_CAP_IR) ir_sh_ff <= `JID_IR_CAPTURE;
      if (state_ff == TAP_SH_IR)  ir_sh_ff <= {tdi_s, ir_sh_ff[`JID_IR_W-1:1]};
      if (state_ff == TAP_UPD_IR) ir_ff <= ir_sh_ff;
    end
  end

  // ==========================================================
  // instruction decode
  wire is_extest = (ir_ff == `JID_IR_EXTEST);
  wire is_sample = (ir_ff == `JID_IR_SAMPLE);
  wire is_idcode = (ir_ff == `JID_IR_IDCODE);
  wire is_fctrl  = (ir_ff == `JID_IR_FL_CTRL);
  wire is_fdata  = (ir_ff == `JID_IR_FL_DATA);
  wire is_faddr  = (ir_ff == `JID_IR_FL_ADDR);
  wire is_fscale = (ir_ff == `JID_IR_FL_SCALE);
  wire is_ind    = is_fctrl | is_fdata | is_faddr | is_fscale;
  // all ones and every unassigned code fall through to bypass
  wire jid_dr_t dr_sel = is_idcode               ? DR_ID  :
                         (is_extest | is_sample) ? DR_BSR :
                         is_ind                  ? DR_IND :
                                                   DR_BYP;
  wire [1:0] ind_idx = is_fctrl ? 2'd0 :
                       is_fdata ? 2'd1 :
                       is_faddr ? 2'd2 : 2'd3;

  // ==========================================================
  // identification and bypass registers
  logic [`JID_ID_W-1:0] id_sh_ff;
  logic                 byp_ff;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      id_sh_ff <= `JID_IDCODE_VAL;
      byp_ff   <= 1'b0;
    end else begin
      if (st_cap_dr && dr_sel == DR_ID) id_sh_ff <= `JID_IDCODE_VAL;
      if (st_sh_dr && dr_sel == DR_ID)  id_sh_ff <= {tdi_s, id_sh_ff[`JID_ID_W-1:1]};
      if (st_cap_dr && dr_sel == DR_BYP) byp_ff <= 1'b0;
      if (st_sh_dr && dr_sel == DR_BYP)  byp_ff <= tdi_s;
    end
  end

  // ==========================================================
  // indirect flash register, shifted in from the top so short writes stay left-justified
  logic [`JID_IND_W-1:0] ind_sh_ff;
  wire ind_is_write = ind_sh_ff[`JID_IND_OP_HI];     // 0x is poll and never updates

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ind_sh_ff <= '0;
    end else if (dr_sel == DR_IND) begin
      if (st_cap_dr) ind_sh_ff <= {1'b0, ind_rdata, ind_busy};
      if (st_sh_dr)  ind_sh_ff <= {tdi_s, ind_sh_ff[`JID_IND_W-1:1]};
    end
  end

  // requests toward the flash interface; one-cycle pulses
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ind_capture <= 1'b0;
      ind_update  <= 1'b0;
      ind_reg_sel <= 2'd0;
      ind_op      <= 2'd0;
      ind_wdata   <= '0;
    end else begin
      ind_capture <= st_cap_dr && dr_sel == DR_IND;
      ind_update  <= st_upd_dr && dr_sel == DR_IND && ind_is_write;
      if (st_upd_dr && dr_sel == DR_IND && ind_is_write) begin
        ind_reg_sel <= ind_idx;
        ind_op      <= ind_sh_ff[`JID_IND_OP_HI:`JID_IND_OP_LO];
        ind_wdata   <= ind_sh_ff[`JID_IND_DATA_W-1:0];
      end
    end
  end

  // ==========================================================
  // boundary register lives outside; this block only steers it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bsr_capture <= 1'b0;
      bsr_shift   <= 1'b0;
      bsr_update  <= 1'b0;
      bsr_tdi     <= 1'b0;
      bsr_extest  <= 1'b0;
      bsr_sel     <= 1'b0;
    end else begin
      bsr_capture <= st_cap_dr && dr_sel == DR_BSR;
      bsr_shift   <= st_sh_dr && dr_sel == DR_BSR;
      bsr_update  <= st_upd_dr && is_extest;          // sample never drives pins
      bsr_tdi     <= tdi_s;
      bsr_extest  <= is_extest;
      bsr_sel     <= dr_sel == DR_BSR;
    end
  end

  // ==========================================================
  // serial output changes on the falling link edge
  wire sh_ir_now = (state_ff == TAP_SH_IR);
  wire sh_dr_now = (state_ff == TAP_SH_DR);
  wire dr_lsb = (dr_sel == DR_ID)  ? id_sh_ff[0]  :
                (dr_sel == DR_BSR) ? bsr_tdo      :
                (dr_sel == DR_IND) ? ind_sh_ff[0] : byp_ff;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= sh_ir_now ? ir_sh_ff[0] : dr_lsb;
      tdo_oe <= sh_ir_now | sh_dr_now;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_id_capture;
    st_cap_dr && is_idcode |=> id_sh_ff == `JID_IDCODE_VAL;
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id capture wrong");

  property p_bypass_shift;
    st_sh_dr && ir_ff == `JID_IR_BYPASS |=> byp_ff == $past(tdi_s);
  endproperty
  a_bypass_shift: assert property (p_bypass_shift) else $error("bypass not shifting");

  property p_ctrl_upd;
    st_upd_dr && is_fctrl && ind_is_write |=> ind_update && ind_reg_sel == 2'd0;
  endproperty
  a_ctrl_upd: assert property (p_ctrl_upd) else $error("control write lost");

  property p_data_upd;
    st_upd_dr && is_fdata && ind_is_write |=> ind_update && ind_reg_sel == 2'd1;
  endproperty
  a_data_upd: assert property (p_data_upd) else $error("data write lost");

  property p_addr_upd;
    st_upd_dr && is_faddr && ind_is_write |=> ind_update && ind_reg_sel == 2'd2;
  endproperty
  a_addr_upd: assert property (p_addr_upd) else $error("address write lost");

  property p_scale_upd;
    st_upd_dr && is_fscale && ind_is_write |=> ind_update && ind_reg_sel == 2'd3;
  endproperty
  a_scale_upd: assert property (p_scale_upd) else $error("scale write lost");

  property p_reset_ir;
    state_ff == TAP_RESET |=> ir_ff == `JID_IR_IDCODE;
  endproperty
  a_reset_ir: assert property (p_reset_ir) else $error("reset ir not idcode");

  property p_sample_no_update;
    is_sample |=> !bsr_update ##1 !bsr_update;
  endproperty
  a_sample_no_update: assert property (p_sample_no_update) else $error("sample drove pins");

  property p_poll_no_update;
    st_upd_dr && dr_sel == DR_IND && !ind_is_write |=> !ind_update;
  endproperty
  a_poll_no_update: assert property (p_poll_no_update) else $error("poll caused update");

  // an unassigned code must capture zero into bypass and leave both other paths quiet
  property p_undef_bypass;
    st_cap_dr && !(is_idcode | is_extest | is_sample | is_ind) |=>
      byp_ff == 1'b0 && !ind_capture && !bsr_capture;
  endproperty
  a_undef_bypass: assert property (p_undef_bypass) else $error("undefined code not bypass");

  c_ind_write: cover property (st_upd_dr && is_fdata && ind_is_write);
  c_id_shift:  cover property (st_sh_dr && is_idcode);
  c_ir_load:   cover property (tck_rise && state_ff == TAP_UPD_IR);

endmodule // jid_top

// ==== verification/jid_link_ctrl.sv ====
`timescale 1ns/10ps

// ==========================================================
// external test controller: drives the link pins, reads tdo
module jid_link_ctrl (
  input  wire logic sys_clk,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  int oe_bad;

  // tck rests low between frames; tdi is not held outside shifts
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    oe_bad = 0;
  end

  // one 80 ns tck period, 40 ns per phase; tdo is read at the rise
  task automatic step(input logic m, input logic d, input logic shifting, output logic o);
    @(posedge sys_clk);
    #1;
    tms = m;
    tdi = d;
    repeat (4) @(posedge sys_clk);
    #1 tck = 1'b1;
    o = tdo;
    if (tdo_oe !== shifting) oe_bad++;  // enable only while a shift is under way
    repeat (5) @(posedge sys_clk);
    #1 tck = 1'b0;
  endtask

  // outside a shift the data line carries a changing pattern, not a held value
  task automatic idle_step(input logic m);
    logic o;
    step(m, ~tdi, 1'b0, o);
  endtask

  // five ones reach test-logic-reset from any state, then park in idle
  task automatic to_idle();
    repeat (5) idle_step(1'b1);
    idle_step(1'b0);
  endtask

  // scan n bits lsb first from idle back to idle; instruction scans shift n bits too, after one extra select step
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    idle_step(1'b1);
    if (ir) idle_step(1'b1);
    idle_step(1'b0);
    idle_step(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b1, o);
      dout[i] = o;
    end
    idle_step(1'b1);
    idle_step(1'b0);
  endtask
endmodule // jid_link_ctrl

// ==== verification/test_jid_top.sv ====
`timescale 1ns/10ps
`include "jid_defs.svh"

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end

// ==========================================================
// bench for the instruction decode behind the test port
module test_jid_top
  import jid_pkg::*;
;
  logic        sys_clk;
  logic        rstn;
  logic        trst_n;
  logic        bsr_tdo = 1'b0;
  logic        ind_busy;
  logic [17:0] ind_rdata;
  wire         tck, tms, tdi, tdo, tdo_oe;
  wire         bsr_capture, bsr_shift, bsr_update, bsr_tdi, bsr_extest, bsr_sel;
  wire         ind_capture, ind_update;
  wire [1:0]   ind_reg_sel, ind_op;
  wire [17:0]  ind_wdata;
  int          n_fail, checks, n_upd, n_icap, n_bcap, n_bupd, n_bsh;
  logic [1:0]  upd_sel, upd_op;
  logic [17:0] upd_wd;
  logic [31:0] o;
  logic [5:0]  bsh_bits;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  jid_top dut_u (.sys_clk, .rstn, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .bsr_tdo,
    .bsr_capture, .bsr_shift, .bsr_update, .bsr_tdi, .bsr_extest, .bsr_sel, .ind_rdata,
    .ind_busy, .ind_capture, .ind_update, .ind_reg_sel, .ind_op, .ind_wdata);

  jid_link_ctrl ctrl_u (.sys_clk, .tdo, .tdo_oe, .tck, .tms, .tdi);

  // pulses last one cycle, so count them and keep what came with the update
  always @(posedge sys_clk) begin
    if (ind_update === 1'b1) begin
      n_upd++;
      upd_sel = ind_reg_sel;
      upd_op = ind_op;
      upd_wd = ind_wdata;
    end
    if (ind_capture === 1'b1) n_icap++;
    if (bsr_capture === 1'b1) n_bcap++;
    if (bsr_update === 1'b1) n_bupd++;
    if (bsr_shift === 1'b1) n_bsh++;
    // serial data handed to the boundary chain, first bit ends up in bit 0
    if (bsr_shift === 1'b1) bsh_bits = {bsr_tdi, bsh_bits[5:1]};
  end

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic load_ir(input logic [15:0] code);
    ctrl_u.scan(1'b1, 16, {16'h0000, code}, o);
    `CHK(o[15:0], 16'h0001)
  endtask

  // identification after reset and again after the test reset pin
  task automatic test_idcode();
    ctrl_u.scan(1'b0, 32, 32'h0000_0000, o);
    `CHK(o, `JID_IDCODE_VAL)
    `CHK(bsr_sel, 1'b0)
    load_ir(`JID_IR_BYPASS);
    @(posedge sys_clk);
    #1 trst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 trst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    ctrl_u.idle_step(1'b0);
    ctrl_u.scan(1'b0, 32, 32'h0000_0000, o);
    `CHK(o, `JID_IDCODE_VAL)
    $display("idcode test done");
  endtask

  // bypass code and unassigned neighbours all give a one-bit path capturing 0
  task automatic test_bypass();
    logic [15:0] codes[5] = '{`JID_IR_BYPASS, 16'h0003, 16'h0081, 16'h0086, 16'h1234};
    int c0;
    foreach (codes[k]) begin
      c0 = n_icap;
      load_ir(codes[k]);
      ctrl_u.scan(1'b0, 8, 32'h0000_00A5, o);
      `CHK(o[7:0], 8'h4A)
      `CHK(n_icap - c0, 0)
      `CHK(bsr_sel, 1'b0)
    end
    $display("bypass test done");
  endtask

  // write to each indirect register, then a poll and a two-bit read
  task automatic test_flash();
    logic [17:0] wd, rd;
    int u0, c0;
    for (int i = 0; i < 4; i++) begin
      rd = 18'h2_5A3C ^ 18'(i);
      wd = 18'h1_0F0F + 18'(i);
      ind_rdata = rd;
      ind_busy = i[0];
      load_ir(16'h0082 + 16'(i));
      u0 = n_upd;
      c0 = n_icap;
      ctrl_u.scan(1'b0, 20, {12'h000, 2'b11, wd}, o);
      repeat (3) @(posedge sys_clk);
      `CHK(o[19:0], {1'b0, rd, i[0]})
      `CHK(n_icap - c0, 1)
      `CHK(n_upd - u0, 1)
      `CHK(upd_sel, 2'(i))
      `CHK(upd_op, 2'b11)
      `CHK(upd_wd, wd)
    end
    u0 = n_upd;
    ctrl_u.scan(1'b0, 20, {12'h000, 2'b01, wd}, o);
    repeat (3) @(posedge sys_clk);
    `CHK(n_upd - u0, 0)
    ctrl_u.scan(1'b0, 2, 32'h0000_0002, o);
    repeat (3) @(posedge sys_clk);
    `CHK(n_upd - u0, 1)
    `CHK(upd_op, 2'b10)
    `CHK(upd_sel, 2'b11)
    $display("flash test done");
  endtask

  // full control updates the pins, observe-only captures but never updates
  task automatic test_boundary();
    int b0, u0, s0;
    for (int k = 0; k < 2; k++) begin
      load_ir(k == 0 ? `JID_IR_EXTEST : `JID_IR_SAMPLE);
      // a steady chain output per pass makes the boundary path visible on tdo
      bsr_tdo = (k == 0);
      `CHK(bsr_sel, 1'b1)
      `CHK(bsr_extest, k == 0)
      b0 = n_bcap;
      u0 = n_bupd;
      s0 = n_bsh;
      ctrl_u.scan(1'b0, 6, 32'h0000_002D, o);
      repeat (3) @(posedge sys_clk);
      `CHK(n_bcap - b0, 1)
      `CHK(n_bsh - s0, 6)
      `CHK(n_bupd - u0, k == 0 ? 1 : 0)
      `CHK(o[5:0], k == 0 ? 6'h3F : 6'h00)
      `CHK(bsh_bits, 6'h2D)
    end
    $display("boundary test done");
  endtask

  // cut a hang short
  initial begin
    repeat (100000) @(posedge sys_clk);
    $display("ERROR t=%0t watchdog expired", $time);
    n_fail++;
    summarize();
  end

  initial begin
    rstn = 1'b0;
    trst_n = 1'b1;
    ind_busy = 1'b0;
    ind_rdata = 18'h0_0000;
    repeat (3) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge sys_clk);
    ctrl_u.to_idle();
    test_idcode();
    test_bypass();
    test_flash();
    test_boundary();
    `CHK(ctrl_u.oe_bad, 0)
    summarize();
  end
endmodule // test_jid_top
